// ---- conv_dec_pkg.sv ----
// Constants, register map and helpers for the soft decoder and monitor
package conv_dec_pkg;
    localparam int SOFT_W     = 6;
    localparam int STATE_W    = 6;
    localparam int NUM_STATES = 64;
    localparam int TB_DEPTH   = 64;
    localparam int LATENCY    = 256;
    localparam int RAM_BLOCKS = 8;
    localparam int RAM_WORDS  = 32;
    localparam int BANKS      = 4;
    localparam int BANK_DEPTH = RAM_BLOCKS * RAM_WORDS / BANKS;
    localparam int SURV_WORDS = BANKS * BANK_DEPTH;
    localparam int CODE_W     = 7;
    localparam logic [CODE_W-1:0] FIRST_GENERATOR_POLY  = 7'h79;
    localparam logic [CODE_W-1:0] SECOND_GENERATOR_POLY = 7'h5B;
    localparam logic signed [7:0] IDEAL_AMP = 8'sh1F;
    localparam int BM_W       = 13;
    localparam int ADDR_W     = 10;
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 10'h204;
    localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 10'h213;
    localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 10'h214;
    localparam int CTRL_WIN_LSB   = 0;
    localparam int CTRL_WIN_MSB   = 1;
    localparam int CTRL_MODE_BIT  = 2;
    localparam int CTRL_START_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO  = 8'h00;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_MAX   = 16'hFFFF;
    localparam int WIN_W = 17;

    // Window length in bits for the two-bit window field
    function automatic logic [WIN_W-1:0] win_len(input logic [1:0] sel);
        logic [WIN_W-1:0] len;
        unique case (sel)
            2'b00: len = 17'h00400;
            2'b01: len = 17'h01000;
            2'b10: len = 17'h04000;
            2'b11: len = 17'h10000;
        endcase
        return len;
    endfunction : win_len

    // Coded pair {first, second} for input u leaving history p
    function automatic logic [1:0] enc(input logic u,
                                       input logic [STATE_W-1:0] p);
        logic [CODE_W-1:0] v;
        v[CODE_W-1] = u;
        for (int i = 0; i < STATE_W; i++) begin
            v[STATE_W-1-i] = p[i];
        end
        return {^(v & FIRST_GENERATOR_POLY), ^(v & SECOND_GENERATOR_POLY)};
    endfunction : enc
endpackage : conv_dec_pkg

// ---- mismatch_window_counter.sv ----
// Re-encoder, mismatch compare and windowed error counter
`timescale 1ns/1ns
module mismatch_window_counter (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        bit_valid,
    input  wire logic                        dec_bit,
    input  wire logic [1:0]                  hard_pair,
    input  wire logic                        run_start,
    input  wire logic                        run_stop,
    input  wire logic                        continuous,
    input  wire logic [1:0]                  win_sel,
    output logic                             running,
    output logic [conv_dec_pkg::CNT_W-1:0]   count
);
    import conv_dec_pkg::*;

    logic [STATE_W-1:0] reenc_q, reenc_d;
    logic               run_q, run_d;
    logic [WIN_W-1:0]   bits_q, bits_d;
    logic [CNT_W-1:0]   acc_q, acc_d;
    logic [CNT_W-1:0]   res_q, res_d;
    logic               done_q, done_d;
    logic [1:0]         good;
    logic [1:0]         nerr;
    logic [CNT_W:0]     sum;

    always_comb begin
        good    = enc(dec_bit, reenc_q); // R7
        nerr    = {1'b0, good[1] ^ hard_pair[1]}
                + {1'b0, good[0] ^ hard_pair[0]}; // R7
        sum     = {1'b0, acc_q} + {{(CNT_W-1){1'b0}}, nerr};
        reenc_d = reenc_q;
        run_d   = run_q;
        bits_d  = bits_q;
        acc_d   = acc_q;
        res_d   = res_q;
        done_d  = 1'b0;
        if (bit_valid) begin
            reenc_d = {reenc_q[STATE_W-2:0], dec_bit};
        end
        if (run_q && bit_valid) begin
            acc_d  = sum[CNT_W] ? COUNT_MAX : sum[CNT_W-1:0]; // R8
            bits_d = bits_q + WIN_W'(1);
            if (bits_d == win_len(win_sel)) begin // R9
                res_d  = acc_d; // R12
                done_d = 1'b1;
                bits_d = '0;
                acc_d  = COUNT_RESET;
                run_d  = continuous; // R12
            end
        end
        if (run_stop) begin
            run_d = 1'b0; // R10
        end
        // Start wins over a window end in the same cycle
        if (run_start) begin
            run_d  = 1'b1; // R10
            bits_d = '0;
            acc_d  = COUNT_RESET;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reenc_q <= '0;
            run_q   <= 1'b0; // R13
            bits_q  <= '0;
            acc_q   <= COUNT_RESET;
            res_q   <= COUNT_RESET; // R13
            done_q  <= 1'b0;
        end else begin
            reenc_q <= reenc_d;
            run_q   <= run_d;
            bits_q  <= bits_d;
            acc_q   <= acc_d;
            res_q   <= res_d;
            done_q  <= done_d;
        end
    end

    assign running = run_q;
    assign count   = res_q;

    sequence s_last_bit;
        run_q && bit_valid && !run_start && !run_stop
            && (bits_q == win_len(win_sel) - WIN_W'(1));
    endsequence

    property p_single_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (s_last_bit and !continuous) |=> (!run_q && done_q)
            ##1 (res_q == $past(res_q));
    endproperty
    a_single_hold: assert property (p_single_hold) // R12
        else $error("single window did not stop and hold");

    property p_cont_restart;
        @(posedge clk_sys) disable iff (!rst_n)
        (s_last_bit and continuous) |=> run_q && done_q
            && bits_q == '0 && acc_q == COUNT_RESET;
    endproperty
    a_cont_restart: assert property (p_cont_restart) // R12
        else $error("continuous window did not restart");

    property p_start;
        @(posedge clk_sys) disable iff (!rst_n)
        run_start |=> run_q && bits_q == '0 && acc_q == COUNT_RESET;
    endproperty
    a_start: assert property (p_start) // R10
        else $error("start did not launch a clean run");

    property p_stop;
        @(posedge clk_sys) disable iff (!rst_n)
        (run_stop && !run_start) |=> !run_q ##1 (!run_q || $past(run_start));
    endproperty
    a_stop: assert property (p_stop) // R10
        else $error("stop did not end the run");

    property p_err_count;
        @(posedge clk_sys) disable iff (!rst_n)
        (run_q && bit_valid && !run_start && good != hard_pair
            && acc_q != COUNT_MAX
            && bits_q < win_len(win_sel) - WIN_W'(1))
            |=> acc_q > $past(acc_q);
    endproperty
    a_err_count: assert property (p_err_count) // R8
        else $error("mismatch not counted");

    property p_generators;
        @(posedge clk_sys) disable iff (!rst_n)
        (reenc_q == '0 && dec_bit) |-> good == 2'b11;
    endproperty
    a_generators: assert property (p_generators) // R3
        else $error("re-encoder taps wrong");

    property p_reset_clear;
        @(posedge clk_sys)
        $rose(rst_n) |-> !run_q && res_q == COUNT_RESET;
    endproperty
    a_reset_clear: assert property (p_reset_clear) // R13
        else $error("counter not cleared by reset");
endmodule : mismatch_window_counter

// ---- conv_soft_decoder_ber_monitor.sv ----
// Soft-decision trellis decoder with input error rate monitor
`timescale 1ns/1ns
// Functional notes
// R1: The decoder takes six-bit soft I and Q samples for every symbol.
// R2: Decoded bits come from trace back over survivors, 64 bits deep.
// R3: The code uses generators 171 octal (first) and 133 octal (second).
// R4: Four branch metrics per symbol are squared distances to ideal points.
// R5: Survivor memory is four banks made of eight 32 by 64 bit blocks.
// R6: A decoded bit leaves 256 bit periods after its symbol entered.
// R7: Decoded bits are re-encoded and compared to delayed hard bits.
// R8: Each mismatch adds to a windowed count that the host can read.
// R9: Window field picks 1024/4096/16384/65536 bits; mode 0 single, 1 loop.
// R10: Host writes start 1 to launch a run and 0 to end any run.
// R11: The 16-bit count reads as low and high bytes at adjacent offsets.
// R12: Single mode holds after one window; continuous latches and restarts.
// R13: Control and count reset to zero with no run until host starts one.
module conv_soft_decoder_ber_monitor #(
    parameter int PM_W = 18
) (
    input  wire logic                                clk_sys,
    input  wire logic                                rst_n,
    input  wire logic                                sym_valid,
    input  wire logic [conv_dec_pkg::SOFT_W-1:0]     sym_i,
    input  wire logic [conv_dec_pkg::SOFT_W-1:0]     sym_q,
    input  wire logic [conv_dec_pkg::ADDR_W-1:0]     reg_addr,
    input  wire logic                                reg_wr_en,
    input  wire logic                                reg_rd_en,
    input  wire logic [7:0]                          reg_wr_data,
    output logic      [7:0]                          reg_rd_data,
    output logic                                     dec_valid,
    output logic                                     dec_bit
);
    import conv_dec_pkg::*;

    localparam int PTR_W    = $clog2(SURV_WORDS);
    localparam int BANK_W   = $clog2(BANKS);
    localparam int TB_STEPS = 2 * TB_DEPTH;
    localparam int TB_CNT_W = $clog2(TB_STEPS);
    localparam int TB_LAST  = TB_STEPS - 1;
    localparam logic [BM_W-1:0] BM_FAR = 13'h1E08;

    typedef enum logic {TB_IDLE, TB_RUN} tb_state_t;

    // Four logical banks, each two 32-word blocks deep
    logic [NUM_STATES-1:0] surv_mem [SURV_WORDS]; // R5
    logic                  dec_mem  [SURV_WORDS];
    logic [1:0]            hard_mem [LATENCY];

    logic [PM_W-1:0]       pm_q [NUM_STATES];
    logic [PM_W-1:0]       pm_d [NUM_STATES];
    logic [NUM_STATES-1:0] surv_vec;
    logic [BM_W-1:0]       bm [4];

    logic [PTR_W-1:0]      wr_ptr_q, wr_ptr_d;
    logic                  primed_q, primed_d;
    tb_state_t             tb_st_q, tb_st_d;
    logic [PTR_W-1:0]      tb_ptr_q, tb_ptr_d;
    logic [STATE_W-1:0]    tb_state_q, tb_state_d;
    logic [TB_CNT_W-1:0]   tb_cnt_q, tb_cnt_d;
    logic                  tb_bit_wr;

    logic                  out_valid_q, out_valid_d;
    logic                  out_bit_q, out_bit_d;
    logic [1:0]            out_hard_q, out_hard_d;

    logic [1:0]            win_sel_q, win_sel_d;
    logic                  mode_q, mode_d;
    logic [7:0]            rd_data_q, rd_data_d;
    logic                  ctrl_wr;
    logic                  running;
    logic [CNT_W-1:0]      count;

    // Squared distance of one soft component to an ideal level
    function automatic logic [BM_W-2:0] sq_dist(
        input logic [SOFT_W-1:0] x, input logic neg);
        logic signed [7:0]  diff;
        logic signed [15:0] sq;
        diff = $signed({{(8-SOFT_W){x[SOFT_W-1]}}, x})
             - (neg ? -IDEAL_AMP : IDEAL_AMP);
        sq = diff * diff;
        return sq[BM_W-2:0];
    endfunction : sq_dist

    // Branch metrics, index is the coded pair; bit 1 maps to negative
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            bm[c] = {1'b0, sq_dist(sym_i, c[1])}
                  + {1'b0, sq_dist(sym_q, c[0])}; // R1 R4
        end
    end

    // Add-compare-select, modular metric compare
    always_comb begin
        logic [STATE_W-1:0] p0;
        logic [STATE_W-1:0] p1;
        logic [PM_W-1:0]    m0;
        logic [PM_W-1:0]    m1;
        logic [PM_W-1:0]    diff;
        p0 = '0;
        p1 = '0;
        m0 = '0;
        m1 = '0;
        diff = '0;
        for (int s = 0; s < NUM_STATES; s++) begin
            p0 = {1'b0, (STATE_W-1)'(s >> 1)};
            p1 = {1'b1, (STATE_W-1)'(s >> 1)};
            m0 = pm_q[p0] + PM_W'(bm[enc(s[0], p0)]); // R3
            m1 = pm_q[p1] + PM_W'(bm[enc(s[0], p1)]); // R3
            diff = m0 - m1;
            surv_vec[s] = !diff[PM_W-1] && (diff != '0);
            pm_d[s] = surv_vec[s] ? m1 : m0;
        end
    end

    // Trace back: at the end of each bank, walk 128 steps from state 0
    always_comb begin
        wr_ptr_d   = wr_ptr_q;
        primed_d   = primed_q;
        tb_st_d    = tb_st_q;
        tb_ptr_d   = tb_ptr_q;
        tb_state_d = tb_state_q;
        tb_cnt_d   = tb_cnt_q;
        tb_bit_wr  = 1'b0;
        if (sym_valid) begin
            wr_ptr_d = wr_ptr_q + PTR_W'(1);
            if (wr_ptr_q == PTR_W'(SURV_WORDS - 1)) begin
                primed_d = 1'b1;
            end
        end
        unique case (tb_st_q)
            TB_IDLE: begin
                if (sym_valid
                    && wr_ptr_q[PTR_W-BANK_W-1:0] == '1) begin // R2
                    tb_st_d    = TB_RUN;
                    tb_ptr_d   = wr_ptr_q;
                    tb_state_d = '0;
                    tb_cnt_d   = '0;
                end
            end
            TB_RUN: begin
                tb_bit_wr  = (tb_cnt_q >= TB_CNT_W'(TB_DEPTH)); // R2
                tb_state_d = {surv_mem[tb_ptr_q][tb_state_q],
                              tb_state_q[STATE_W-1:1]}; // R2
                tb_ptr_d   = tb_ptr_q - PTR_W'(1);
                tb_cnt_d   = tb_cnt_q + TB_CNT_W'(1);
                if (tb_cnt_q == TB_CNT_W'(TB_STEPS - 1)) begin
                    tb_st_d = TB_IDLE;
                end
            end
        endcase
    end

    // Output bit and hard pair from exactly LATENCY symbols ago
    always_comb begin
        out_valid_d = sym_valid && primed_q; // R6
        out_bit_d   = out_bit_q;
        out_hard_d  = out_hard_q;
        if (sym_valid) begin
            out_bit_d  = dec_mem[wr_ptr_q]; // R6
            out_hard_d = hard_mem[wr_ptr_q]; // R7
        end
    end

    // Host registers
    always_comb begin
        ctrl_wr   = reg_wr_en && reg_addr == ADDR_CTRL;
        win_sel_d = win_sel_q;
        mode_d    = mode_q;
        rd_data_d = rd_data_q;
        if (ctrl_wr) begin
            win_sel_d = reg_wr_data[CTRL_WIN_MSB:CTRL_WIN_LSB]; // R9
            mode_d    = reg_wr_data[CTRL_MODE_BIT]; // R9
        end
        if (reg_rd_en) begin
            unique case (reg_addr)
                ADDR_CTRL: begin
                    rd_data_d = READ_ZERO;
                    rd_data_d[CTRL_WIN_MSB:CTRL_WIN_LSB] = win_sel_q;
                    rd_data_d[CTRL_MODE_BIT]  = mode_q;
                    rd_data_d[CTRL_START_BIT] = running;
                end
                ADDR_CNT_LO: rd_data_d = count[7:0]; // R11
                ADDR_CNT_HI: rd_data_d = count[CNT_W-1:8]; // R11
                default:     rd_data_d = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sym_valid) begin
            surv_mem[wr_ptr_q] <= surv_vec; // R5
            hard_mem[wr_ptr_q] <= {sym_i[SOFT_W-1], sym_q[SOFT_W-1]};
        end
        if (tb_bit_wr) begin
            dec_mem[tb_ptr_q] <= tb_state_q[0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int s = 0; s < NUM_STATES; s++) begin
                pm_q[s] <= '0;
            end
            wr_ptr_q    <= '0;
            primed_q    <= 1'b0;
            tb_st_q     <= TB_IDLE;
            tb_ptr_q    <= '0;
            tb_state_q  <= '0;
            tb_cnt_q    <= '0;
            out_valid_q <= 1'b0;
            out_bit_q   <= 1'b0;
            out_hard_q  <= '0;
            win_sel_q   <= CTRL_RESET[CTRL_WIN_MSB:CTRL_WIN_LSB]; // R13
            mode_q      <= CTRL_RESET[CTRL_MODE_BIT]; // R13
            rd_data_q   <= READ_ZERO;
        end else begin
            if (sym_valid) begin
                pm_q <= pm_d;
            end
            wr_ptr_q    <= wr_ptr_d;
            primed_q    <= primed_d;
            tb_st_q     <= tb_st_d;
            tb_ptr_q    <= tb_ptr_d;
            tb_state_q  <= tb_state_d;
            tb_cnt_q    <= tb_cnt_d;
            out_valid_q <= out_valid_d;
            out_bit_q   <= out_bit_d;
            out_hard_q  <= out_hard_d;
            win_sel_q   <= win_sel_d;
            mode_q      <= mode_d;
            rd_data_q   <= rd_data_d;
        end
    end

    mismatch_window_counter u_counter (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .bit_valid  (out_valid_q),
        .dec_bit    (out_bit_q),
        .hard_pair  (out_hard_q),
        .run_start  (ctrl_wr && reg_wr_data[CTRL_START_BIT]), // R10
        .run_stop   (ctrl_wr && !reg_wr_data[CTRL_START_BIT]), // R10
        .continuous (mode_q),
        .win_sel    (win_sel_q),
        .running    (running),
        .count      (count)
    );

    assign dec_valid   = out_valid_q;
    assign dec_bit     = out_bit_q;
    assign reg_rd_data = rd_data_q;

    sequence s_tb_begin;
        tb_st_q == TB_IDLE ##1 tb_st_q == TB_RUN;
    endsequence

    property p_tb_length;
        @(posedge clk_sys) disable iff (!rst_n)
        s_tb_begin |-> ##TB_LAST (tb_st_q == TB_RUN) ##1 (tb_st_q == TB_IDLE);
    endproperty
    a_tb_length: assert property (p_tb_length) // R2
        else $error("trace back not 128 steps");

    property p_bank_split;
        @(posedge clk_sys) disable iff (!rst_n)
        tb_st_q == TB_RUN |-> tb_ptr_q[PTR_W-1 -: BANK_W]
                              != wr_ptr_q[PTR_W-1 -: BANK_W];
    endproperty
    a_bank_split: assert property (p_bank_split) // R5
        else $error("trace back reads the bank being written");

    property p_metric;
        @(posedge clk_sys) disable iff (!rst_n)
        (sym_i == SOFT_W'(IDEAL_AMP) && sym_q == SOFT_W'(IDEAL_AMP))
            |-> bm[0] == '0 && bm[3] == BM_FAR;
    endproperty
    a_metric: assert property (p_metric) // R4
        else $error("branch metric is not squared distance");

    property p_latency;
        @(posedge clk_sys) disable iff (!rst_n)
        (sym_valid && !primed_q) |=> !dec_valid;
    endproperty
    a_latency: assert property (p_latency) // R6
        else $error("decoded bit before 256 symbols");

    property p_read_hi;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rd_en && reg_addr == ADDR_CNT_HI)
            |=> reg_rd_data == $past(count[CNT_W-1:8]);
    endproperty
    a_read_hi: assert property (p_read_hi) // R11
        else $error("high count byte read wrong");
endmodule : conv_soft_decoder_ber_monitor

// ---- qpsk_symbol_source.sv ----
// Demodulator-side model: coded soft symbols with periodic sign errors
`timescale 1ns/1ns
module qpsk_symbol_source #(
    parameter int FLIP_EVERY = 16
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    output logic                           sym_valid,
    output logic [conv_dec_pkg::SOFT_W-1:0] sym_i,
    output logic [conv_dec_pkg::SOFT_W-1:0] sym_q,
    output logic                           src_bit
);
    import conv_dec_pkg::*;
    logic [5:0] hist;
    logic [6:0] v;
    logic       c1;
    logic       c2;
    int         gap;
    int         nsent;
    initial begin
        sym_valid = 1'b0;
        sym_i = 6'h00;
        sym_q = 6'h00;
        src_bit = 1'b0;
        hist = 6'h00;
        gap = 2;
        nsent = 0;
    end
    always @(negedge clk_sys) begin
        if (rst_n && gap == 0) begin
            src_bit = 1'($urandom_range(1, 0));
            v[6] = src_bit;
            for (int i = 0; i < 6; i++) begin
                v[5-i] = hist[i];
            end
            c1 = ^(v & 7'h79);
            c2 = ^(v & 7'h5B);
            // Sign error on I every FLIP_EVERY symbols
            if (nsent % FLIP_EVERY == FLIP_EVERY - 1) begin
                c1 = ~c1;
            end
            sym_i = c1 ? 6'h21 : 6'h1F;
            sym_q = c2 ? 6'h21 : 6'h1F;
            hist = {hist[4:0], src_bit};
            nsent++;
            gap = $urandom_range(4, 2);
            sym_valid = 1'b1;
        end else begin
            // Idle lines invert the last symbol on every idle cycle
            sym_valid = 1'b0;
            sym_i = ~sym_i;
            sym_q = ~sym_q;
            if (!rst_n) begin
                hist = 6'h00;
                nsent = 0;
                gap = 2;
            end else begin
                gap--;
            end
        end
    end
endmodule : qpsk_symbol_source

// ---- tb_conv_soft_decoder_ber_monitor.sv ----
// Self-checking bench for the soft decoder and error monitor
`timescale 1ns/1ns
module tb_conv_soft_decoder_ber_monitor;
    import conv_dec_pkg::*;
    localparam int FLIP_EVERY = 16;
    localparam int LIMIT      = 80000;
    logic              clk_sys;
    logic              rst_n;
    logic              sym_valid;
    logic [SOFT_W-1:0] sym_i;
    logic [SOFT_W-1:0] sym_q;
    logic              src_bit;
    logic [ADDR_W-1:0] reg_addr;
    logic              reg_wr_en;
    logic              reg_rd_en;
    logic [7:0]        reg_wr_data;
    logic [7:0]        reg_rd_data;
    logic              dec_valid;
    logic              dec_bit;
    logic [7:0]        rd;
    logic [7:0]        v;
    logic [15:0]       cnt;
    int                error_cnt;
    int                checks_done;
    int                cycles;
    int                nsym;
    int                ndec;
    int                n0;
    bit                q[$];

    conv_soft_decoder_ber_monitor conv_soft_decoder_ber_monitor_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .sym_valid(sym_valid),
        .sym_i(sym_i), .sym_q(sym_q), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .dec_valid(dec_valid), .dec_bit(dec_bit));
    qpsk_symbol_source #(.FLIP_EVERY(FLIP_EVERY)) qpsk_symbol_source_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .sym_valid(sym_valid),
        .sym_i(sym_i), .sym_q(sym_q), .src_bit(src_bit));

    always #4 clk_sys = ~clk_sys;

    function automatic logic [15:0] exp_errs(input logic [1:0] sel);
        return 16'((1024 << (2 * sel)) / FLIP_EVERY);
    endfunction : exp_errs

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wr_data = ~d;
    endtask : reg_wr

    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        @(negedge clk_sys);
        d = reg_rd_data;
    endtask : reg_rd

    task automatic read_count(output logic [15:0] c);
        logic [7:0] lo;
        logic [7:0] hi;
        reg_rd(ADDR_CNT_LO, lo);
        reg_rd(ADDR_CNT_HI, hi);
        c = {hi, lo};
    endtask : read_count

    task automatic wait_idle();
        logic [7:0] r;
        int n;
        n = 0;
        do begin
            reg_rd(ADDR_CTRL, r);
            n++;
        end while (r[CTRL_START_BIT] !== 1'b0 && n < 30000);
    endtask : wait_idle

    // Decoded stream against the source bits, 256 symbols behind
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            error_cnt++;
            $display("ERROR %0t: run exceeded cycle ceiling", $time);
            summarize();
        end
        if (!rst_n) begin
            q.delete();
            nsym = 0;
            ndec = 0;
        end else begin
            if (sym_valid) begin
                q.push_back(src_bit);
                nsym++;
            end
            if (dec_valid && q.size() > 0) begin
                if (ndec >= 512) begin
                    check(dec_bit, q[0], "decoded bit");
                end
                void'(q.pop_front());
                ndec++;
            end
        end
    end

    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_wr_data = 8'h00;
        error_cnt = 0;
        checks_done = 0;
        cycles = 0;
        void'($urandom(90246));
        repeat (5) @(negedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        check(reg_rd_data, 16'h0000, "read data after reset");
        check(dec_valid, 16'h0000, "decoded valid after reset");
        reg_rd(ADDR_CTRL, rd);
        check(rd, 16'h0000, "control after reset");
        read_count(cnt);
        check(cnt, 16'h0000, "count after reset");
        reg_rd(10'h000, rd);
        check(rd, 16'h0000, "unmapped read");
        reg_wr(ADDR_CNT_LO, 8'hA5);
        reg_wr(ADDR_CNT_HI, 8'h5A);
        read_count(cnt);
        check(cnt, 16'h0000, "count after host write");
        $display("test reset_values done");
        for (int s = 0; s < 4; s++) begin
            v = 8'($urandom) & 8'hF4;
            v[1:0] = 2'(s);
            reg_wr(ADDR_CTRL, v);
            reg_rd(ADDR_CTRL, rd);
            check(rd, {8'h00, v & 8'h0F}, "control readback");
        end
        reg_wr(ADDR_CTRL, 8'h00);
        $display("test control_fields done");
        wait (nsym >= 800);
        reg_wr(ADDR_CTRL, 8'h08);
        reg_rd(ADDR_CTRL, rd);
        check(rd, 16'h0008, "single run active");
        wait_idle();
        read_count(cnt);
        check(cnt, exp_errs(2'b00), "single window count");
        n0 = ndec;
        wait (ndec >= n0 + 1100);
        read_count(cnt);
        check(cnt, exp_errs(2'b00), "single count held");
        reg_rd(ADDR_CTRL, rd);
        check(rd, 16'h0000, "single run ended");
        $display("test single_1024 done");
        reg_wr(ADDR_CTRL, 8'h0C);
        n0 = ndec;
        wait (ndec >= n0 + 1500);
        reg_rd(ADDR_CTRL, rd);
        check(rd, 16'h000C, "continuous still running");
        read_count(cnt);
        check(cnt, exp_errs(2'b00), "continuous window count");
        reg_wr(ADDR_CTRL, 8'h04);
        reg_rd(ADDR_CTRL, rd);
        check(rd, 16'h0004, "continuous run ended");
        $display("test continuous done");
        reg_wr(ADDR_CTRL, 8'h09);
        wait_idle();
        read_count(cnt);
        check(cnt, exp_errs(2'b01), "single 4096 count");
        $display("test single_4096 done");
        reg_wr(ADDR_CTRL, 8'h08);
        n0 = ndec;
        wait (ndec >= n0 + 200);
        reg_wr(ADDR_CTRL, 8'h00);
        reg_rd(ADDR_CTRL, rd);
        check(rd, 16'h0000, "aborted run stopped");
        wait (ndec >= n0 + 1300);
        read_count(cnt);
        check(cnt, exp_errs(2'b01), "aborted run kept result");
        $display("test abort done");
        summarize();
    end
endmodule : tb_conv_soft_decoder_ber_monitor
